// [inc/bdm_defs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef BDM_DEFS_SVH
`define BDM_DEFS_SVH
`define BDM_CLK_NS          5
`define BDM_ADDR_W          5
`define BDM_OFS_CTRL        5'h00
`define BDM_OFS_DEMAND      5'h04
`define BDM_OFS_CONFIG      5'h08
`define BDM_OFS_RAMP        5'h0c
`define BDM_OFS_STATUS      5'h10
`define BDM_OFS_SPEED       5'h14
`define BDM_CTRL_RUN        0
`define BDM_CTRL_RESTART    1
`define BDM_CTRL_MODE_LO    2
`define BDM_CTRL_LIMIT_EN   4
`define BDM_CTRL_DIAG_SEL   5
`define BDM_CFG_PWM_LO      0
`define BDM_CFG_RES_LO      8
`define BDM_CFG_MIT_LO      12
`define BDM_CFG_US_LO       16
`define BDM_RST_CTRL        32'h0000_0000
`define BDM_RST_CONFIG      32'h0000_0000
`define BDM_RST_RAMP        16'h0064
`define BDM_PWM_BASE_NS     10000
`define BDM_PWM_STEP_NS     200
`define BDM_PWM_BASE_CYC    (`BDM_PWM_BASE_NS / `BDM_CLK_NS)
`define BDM_PWM_STEP_CYC    (`BDM_PWM_STEP_NS / `BDM_CLK_NS)
`define BDM_US_STEP         16'h000a
`define BDM_DUTY_FULL       10'h3ff
`endif

// [inc/bdm_pkg.sv]
// Types shared by the demand mode controller
package bdm_pkg;
  typedef enum logic [1:0] {
    BDM_MODE_OPEN,
    BDM_MODE_CURRENT,
    BDM_MODE_SPEED,
    BDM_MODE_RSVD
  } bdm_mode_t;

  typedef enum {
    BDM_ST_COAST,
    BDM_ST_RUN,
    BDM_ST_LOST
  } bdm_state_t;

  typedef struct packed {
    logic      diag_read_sel;
    logic      current_limit_en;
    bdm_mode_t mode;
    logic      auto_restart_enable;
    logic      run;
  } bdm_ctrl_t;

  typedef struct packed {
    logic [3:0] underspeed_threshold_sel;
    logic [3:0] max_current_threshold_sel;
    logic [2:0] speed_resolution_sel;
    logic [5:0] bridge_pwm_freq_sel;
  } bdm_cfg_t;
endpackage

// [src/bdm_ctrl.sv]
// Demand mode controller: Avalon-MM registers, mode mapping, speed loop, sync loss
`include "bdm_defs.svh"

// Functional notes
// - Open-loop: demand sets bridge duty directly
// - PWM frequency set by six-bit selector
// - Duty is peak fed to waveform generator
// - No minimum or maximum duty clamp
// - Current limit stays active when enabled
// - Speed below underspeed threshold flags sync loss
// - Open/current: auto-restart while run, restart, demand
// - No restart: hold lost until clear condition
// - Current mode: threshold scales with demand
// - Current mode uses top five demand bits
// - Reference equals demand times selected resolution
// - Resolution doubles from 0.1 Hz per code; codes 6 and 7 act as code 5
// - Speeds are electrical cycle frequency
// - Speed loop steps duty toward reference
// - Speed mode coasts until reference exceeds ramp end
// - Speed mode loss: bridge off, flag set
// - Speed mode no restart: off until stop
// - Speed mode auto-restart above ramp end speed
// - Speed mode keeps current limiter active
// - Run low forces coast, overrides all
// - Demand is ten-bit, meaning per mode
module bdm_ctrl
  import bdm_pkg::*;
#(
  parameter int DEMAND_W = 10,
  parameter int PWM_BASE = `BDM_PWM_BASE_CYC,
  parameter int PWM_STEP = `BDM_PWM_STEP_CYC
)(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [`BDM_ADDR_W-1:0] address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  input  wire logic [15:0]            motor_speed,
  input  wire logic                   seq_synced,
  output logic                        seq_start,
  output logic                        seq_reset,
  output logic                        bridge_enable,
  output logic                        bridge_pwm,
  output logic      [9:0]             peak_duty,
  output logic                        current_limit_active,
  output logic      [4:0]             current_threshold,
  output logic      [3:0]             max_current_threshold_sel,
  output logic                        sync_lost_flag
);
  generate
    if (DEMAND_W != 10 || PWM_BASE < 2 || PWM_STEP < 0 || PWM_BASE + 63 * PWM_STEP > 65535)
    begin : g_chk
      $error("bdm_ctrl: unsupported parameter values");
    end
  endgenerate

  bdm_ctrl_t  ctrl_q;
  bdm_cfg_t   cfg_q;
  logic [9:0]  demand_input_q;
  logic [15:0] start_ramp_end_speed_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  bdm_state_t  state_q;
  logic [15:0] pwm_cnt_q;
  logic [9:0]  loop_duty_q;
  logic        seq_start_q;
  logic        seq_reset_q;
  logic        lost_q;
  logic        pwm_q;

  // Reference speed in 0.1 Hz steps of electrical frequency
  function automatic logic [15:0] ref_speed(input logic [9:0] d, input logic [2:0] s);
    logic [2:0] sh;
    sh = (s > 3'h5) ? 3'h5 : s;
    ref_speed = 16'(d) << sh;
  endfunction

  function automatic logic [15:0] pwm_period(input logic [5:0] sel);
    pwm_period = 16'(PWM_BASE + int'(sel) * PWM_STEP);
  endfunction

  logic        req;
  logic        acc;
  logic        wr_en;
  logic        status_rd;
  logic [15:0] speed_ref;
  logic [15:0] underspeed_frequency;
  logic [15:0] period;
  logic        pwm_tick;
  logic        start_ok;
  logic        stop_req;
  logic        loss;
  logic        lost_clear;

  assign req         = read | write;
  assign acc         = req & ack_q;
  assign wr_en       = write & ack_q;
  assign waitrequest = req & ~ack_q;
  assign readdata    = rdata_q;
  assign status_rd   = read & ack_q & (address == `BDM_OFS_STATUS) & ~ctrl_q.diag_read_sel;

  assign speed_ref = ref_speed(demand_input_q, cfg_q.speed_resolution_sel);
  assign underspeed_frequency =
    16'((int'(cfg_q.underspeed_threshold_sel) + 1) * int'(`BDM_US_STEP));
  assign period   = pwm_period(cfg_q.bridge_pwm_freq_sel);
  assign pwm_tick = (pwm_cnt_q >= period - 16'h0001);

  // Start permitted: speed mode waits for ramp end speed
  assign start_ok = (ctrl_q.mode == BDM_MODE_SPEED) ?
                    (speed_ref > start_ramp_end_speed_q) :
                    (demand_input_q != 10'h000);
  assign stop_req = ~ctrl_q.run | (demand_input_q == 10'h000);
  assign loss     = seq_synced & (motor_speed < underspeed_frequency);
  assign lost_clear = stop_req | (status_rd & (ctrl_q.mode != BDM_MODE_SPEED));

  // Bus handshake: answer one cycle after the request appears
  always_ff @(posedge clk)
  begin
    if (!nrst)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata_q <= 32'h0000_0000;
    else if (read & ~ack_q)
    begin
      case (address)
        `BDM_OFS_CTRL:   rdata_q <= {26'h0, ctrl_q};
        `BDM_OFS_DEMAND: rdata_q <= {22'h0, demand_input_q};
        `BDM_OFS_CONFIG: rdata_q <= {12'h0, cfg_q.underspeed_threshold_sel,
                                     cfg_q.max_current_threshold_sel, 1'b0,
                                     cfg_q.speed_resolution_sel, 2'h0,
                                     cfg_q.bridge_pwm_freq_sel};
        `BDM_OFS_RAMP:   rdata_q <= {16'h0, start_ramp_end_speed_q};
        `BDM_OFS_STATUS: rdata_q <= {28'h0, peak_duty == `BDM_DUTY_FULL,
                                     state_q == BDM_ST_LOST, bridge_enable, lost_q};
        `BDM_OFS_SPEED:  rdata_q <= {motor_speed, speed_ref};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_q                 <= bdm_ctrl_t'(6'(`BDM_RST_CTRL));
      cfg_q                  <= bdm_cfg_t'(17'(`BDM_RST_CONFIG));
      demand_input_q         <= 10'h000;
      start_ramp_end_speed_q <= `BDM_RST_RAMP;
    end
    else if (wr_en)
    begin
      case (address)
        `BDM_OFS_CTRL:   ctrl_q <= bdm_ctrl_t'(writedata[5:0]);
        `BDM_OFS_DEMAND: demand_input_q <= writedata[9:0];
        `BDM_OFS_CONFIG:
        begin
          cfg_q.bridge_pwm_freq_sel       <= writedata[`BDM_CFG_PWM_LO +: 6];
          cfg_q.speed_resolution_sel      <= writedata[`BDM_CFG_RES_LO +: 3];
          cfg_q.max_current_threshold_sel <= writedata[`BDM_CFG_MIT_LO +: 4];
          cfg_q.underspeed_threshold_sel  <= writedata[`BDM_CFG_US_LO +: 4];
        end
        `BDM_OFS_RAMP:   start_ramp_end_speed_q <= writedata[15:0];
        default:         ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Bridge PWM period counter
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pwm_cnt_q <= 16'h0000;
    else if (pwm_tick)
      pwm_cnt_q <= 16'h0000;
    else
      pwm_cnt_q <= pwm_cnt_q + 16'h0001;
  end

  // Run state machine
  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_q <= BDM_ST_COAST;
    else if (!ctrl_q.run)
      state_q <= BDM_ST_COAST;
    else
    begin
      case (state_q)
        BDM_ST_COAST:
          if (start_ok)
            state_q <= BDM_ST_RUN;
        BDM_ST_RUN:
          if (!start_ok && ctrl_q.mode == BDM_MODE_SPEED && !loss)
            state_q <= BDM_ST_COAST;
          else if (stop_req)
            state_q <= BDM_ST_COAST;
          else if (loss && !(ctrl_q.auto_restart_enable && start_ok))
            state_q <= BDM_ST_LOST;
        BDM_ST_LOST:
          if (lost_clear)
            state_q <= BDM_ST_COAST;
        default:
          state_q <= BDM_ST_COAST;
      endcase
    end
  end

  // Sequencer start and restart pulses
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      seq_start_q <= 1'b0;
      seq_reset_q <= 1'b0;
    end
    else
    begin
      seq_start_q <= ctrl_q.run & (state_q == BDM_ST_COAST) & start_ok;
      seq_reset_q <= ctrl_q.run & ~stop_req & (state_q == BDM_ST_RUN) & loss &
                     ctrl_q.auto_restart_enable & start_ok;
    end
  end

  // Sticky loss flag; a new loss wins over the read clear
  always_ff @(posedge clk)
  begin
    if (!nrst)
      lost_q <= 1'b0;
    else if (state_q == BDM_ST_RUN && loss && ctrl_q.run)
      lost_q <= 1'b1;
    else if (status_rd)
      lost_q <= 1'b0;
  end

  // Speed loop sampled once per bridge PWM period
  always_ff @(posedge clk)
  begin
    if (!nrst)
      loop_duty_q <= 10'h000;
    else if (state_q != BDM_ST_RUN || ctrl_q.mode != BDM_MODE_SPEED)
      loop_duty_q <= 10'h000;
    else if (pwm_tick)
    begin
      if (motor_speed < speed_ref && loop_duty_q != `BDM_DUTY_FULL)
        loop_duty_q <= loop_duty_q + 10'h001;
      else if (motor_speed > speed_ref && loop_duty_q != 10'h000)
        loop_duty_q <= loop_duty_q - 10'h001;
    end
  end

  // Peak duty and current threshold per mode
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      peak_duty            <= 10'h000;
      current_threshold    <= 5'h00;
      current_limit_active <= 1'b0;
    end
    else
    begin
      case (ctrl_q.mode)
        BDM_MODE_OPEN:
        begin
          peak_duty            <= demand_input_q;
          current_threshold    <= 5'h1f;
          current_limit_active <= ctrl_q.current_limit_en;
        end
        BDM_MODE_CURRENT:
        begin
          peak_duty            <= `BDM_DUTY_FULL;
          current_threshold    <= demand_input_q[9:5];
          current_limit_active <= 1'b1;
        end
        BDM_MODE_SPEED:
        begin
          peak_duty            <= loop_duty_q;
          current_threshold    <= 5'h1f;
          current_limit_active <= 1'b1;
        end
        default:
        begin
          peak_duty            <= 10'h000;
          current_threshold    <= 5'h00;
          current_limit_active <= 1'b0;
        end
      endcase
    end
  end

  // Bridge PWM level: high while count is below duty share of period
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pwm_q <= 1'b0;
    else
      pwm_q <= (state_q == BDM_ST_RUN) & ctrl_q.run &
               (26'(pwm_cnt_q) * 26'(`BDM_DUTY_FULL) < 26'(peak_duty) * 26'(period));
  end

  assign bridge_enable             = (state_q == BDM_ST_RUN) & ctrl_q.run;
  assign bridge_pwm                = pwm_q & bridge_enable;
  assign seq_start                 = seq_start_q;
  assign seq_reset                 = seq_reset_q;
  assign sync_lost_flag            = lost_q;
  assign max_current_threshold_sel = cfg_q.max_current_threshold_sel;

  sequence s_loss_run;
    state_q == BDM_ST_RUN && loss && ctrl_q.run;
  endsequence

  sequence s_restart_ok;
    ctrl_q.auto_restart_enable && start_ok && !stop_req;
  endsequence

  AST_RUN_LOW_COAST: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl_q.run |=> !bridge_enable && !bridge_pwm)
    else $error("bridge active with run low");
  AST_LOSS_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    s_loss_run |=> sync_lost_flag)
    else $error("loss not flagged");
  AST_RESTART: assert property (@(posedge clk) disable iff (!nrst)
    s_loss_run ##0 s_restart_ok |=> seq_reset && bridge_enable)
    else $error("no restart pulse");
  AST_HOLD_LOST: assert property (@(posedge clk) disable iff (!nrst)
    state_q == BDM_ST_LOST && !lost_clear && ctrl_q.run |=> state_q == BDM_ST_LOST)
    else $error("left lost state early");
  AST_SPEED_OFF: assert property (@(posedge clk) disable iff (!nrst)
    s_loss_run ##0 !(ctrl_q.auto_restart_enable && start_ok && !stop_req) |=> !bridge_enable)
    else $error("bridge on after loss");
  AST_CUR_THR: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_q.mode == BDM_MODE_CURRENT |=> current_threshold == $past(demand_input_q[9:5]))
    else $error("current threshold mismatch");
  AST_OPEN_DUTY: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_q.mode == BDM_MODE_OPEN |=> peak_duty == $past(demand_input_q))
    else $error("open-loop duty mismatch");
  AST_COAST_LOW_REF: assert property (@(posedge clk) disable iff (!nrst)
    state_q == BDM_ST_COAST && ctrl_q.mode == BDM_MODE_SPEED && !start_ok
    |=> state_q == BDM_ST_COAST)
    else $error("speed mode started below ramp end");
  AST_LIMIT_SPEED: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_q.mode == BDM_MODE_SPEED [*2] |-> current_limit_active)
    else $error("limiter off in speed mode");
  AST_REF: assert property (@(posedge clk) disable iff (!nrst)
    cfg_q.speed_resolution_sel == 3'h1 |-> speed_ref == {5'h00, demand_input_q, 1'b0})
    else $error("reference scaling wrong");
endmodule

// [bench/bdm_motor.sv]
// Behavioural sequencer and motor standing behind the bridge
module bdm_motor
  import bdm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        seq_start,
  input  wire logic        seq_reset,
  input  wire logic        bridge_enable,
  input  wire logic        stall,
  output logic      [15:0] motor_speed,
  output logic             seq_synced
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;

  // Sync is lost whenever drive stops or the sequencer restarts
  always_ff @(posedge clk)
  begin
    if (!nrst || !bridge_enable || seq_start || seq_reset)
    begin
      cnt_q      <= 4'h0;
      seq_synced <= 1'b0;
    end
    else if (cnt_q != 4'hf)
      cnt_q <= cnt_q + 4'h1;
    else
      seq_synced <= 1'b1;
  end

  // A stalled motor reads 0.5 Hz, otherwise 50 Hz
  always_ff @(posedge clk)
  begin
    motor_speed <= stall ? 16'h0005 : 16'h01f4;
  end
endmodule

// [bench/bldc_demand_mode_controller_bench.sv]
// Self-checking bench for the demand mode controller
`include "bdm_defs.svh"
module bldc_demand_mode_controller_bench
  import bdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, read, write, waitrequest, seq_synced, seq_start, seq_reset;
  logic        bridge_enable, bridge_pwm, current_limit_active, sync_lost_flag, stall, pwm_d;
  logic [4:0]  address, current_threshold;
  logic [31:0] writedata, readdata, q;
  logic [15:0] motor_speed;
  logic [9:0]  peak_duty, d0;
  logic [3:0]  max_current_threshold_sel;
  int          n_fail, total_checks, n_rst, n_st, cyc, last_rise, pwm_per, k0;

  bdm_ctrl #(
    .PWM_BASE (20),
    .PWM_STEP (1)
  ) bdm_ctrl_i (
    .clk                       (clk),
    .nrst                      (nrst),
    .address                   (address),
    .read                      (read),
    .write                     (write),
    .writedata                 (writedata),
    .readdata                  (readdata),
    .waitrequest               (waitrequest),
    .motor_speed               (motor_speed),
    .seq_synced                (seq_synced),
    .seq_start                 (seq_start),
    .seq_reset                 (seq_reset),
    .bridge_enable             (bridge_enable),
    .bridge_pwm                (bridge_pwm),
    .peak_duty                 (peak_duty),
    .current_limit_active      (current_limit_active),
    .current_threshold         (current_threshold),
    .max_current_threshold_sel (max_current_threshold_sel),
    .sync_lost_flag            (sync_lost_flag)
  );

  bdm_motor bdm_motor_i (
    .clk           (clk),
    .nrst          (nrst),
    .seq_start     (seq_start),
    .seq_reset     (seq_reset),
    .bridge_enable (bridge_enable),
    .stall         (stall),
    .motor_speed   (motor_speed),
    .seq_synced    (seq_synced)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts restart pulses and measures the bridge PWM period
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    pwm_d <= bridge_pwm;
    if (seq_reset === 1'b1)
      n_rst <= n_rst + 1;
    if (seq_start === 1'b1)
      n_st <= n_st + 1;
    if (bridge_pwm === 1'b1 && pwm_d === 1'b0)
    begin
      pwm_per <= cyc - last_rise;
      last_rise <= cyc;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request stands until the edge at which waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_for(ref logic s, input logic v, input string what);
    for (int n = 0; n < 400 && s !== v; n++)
      @(negedge clk);
    chk(what, s, v);
  endtask

  task automatic set_stall(input logic v);
    @(posedge clk);
    stall <= v;
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    {nrst, read, write, stall, pwm_d, address, writedata} = '0;
    {n_fail, total_checks, n_rst, n_st, cyc, last_rise, pwm_per} = '0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(`BDM_OFS_CTRL);
    chk("ctrl reset", q, `BDM_RST_CTRL);
    rd(`BDM_OFS_RAMP);
    chk("ramp reset", q, 32'h64);
    rd(`BDM_OFS_CONFIG);
    chk("config reset", q, `BDM_RST_CONFIG);
    rd(5'h18);
    chk("unmapped read", q, 32'h0);
    // Open loop, PWM selector 5, threshold selector 9
    wr(`BDM_OFS_CONFIG, 32'h0000_9005);
    wr(`BDM_OFS_DEMAND, 32'h200);
    wr(`BDM_OFS_CTRL, 32'h11);
    wait_for(seq_synced, 1'b1, "open start");
    ticks(80);
    chk("pwm period", 32'(pwm_per), 32'd25);
    chk("limit open", current_limit_active, 1'b1);
    chk("max thr sel", max_current_threshold_sel, 4'h9);
    wr(`BDM_OFS_DEMAND, 32'h5);
    ticks(30);
    chk("duty low", peak_duty, 10'h005);
    wr(`BDM_OFS_DEMAND, 32'h3ff);
    ticks(30);
    chk("duty full", peak_duty, 10'h3ff);
    rd(`BDM_OFS_STATUS);
    chk("status full", q[3], 1'b1);
    // Loss with restart off holds the lost state
    set_stall(1'b1);
    wait_for(sync_lost_flag, 1'b1, "open loss");
    ticks(2);
    chk("lost off", bridge_enable, 1'b0);
    ticks(40);
    chk("lost held", bridge_enable, 1'b0);
    set_stall(1'b0);
    rd(`BDM_OFS_STATUS);
    chk("status lost", q[2:0], 3'b101);
    rd(`BDM_OFS_STATUS);
    chk("status clear", q[0], 1'b0);
    // Auto restart repeats until demand is zero
    wr(`BDM_OFS_CTRL, 32'h13);
    wait_for(seq_synced, 1'b1, "resync");
    k0 = n_rst;
    set_stall(1'b1);
    ticks(120);
    chk("restarts", 32'(n_rst - k0 >= 2), 32'h1);
    wr(`BDM_OFS_DEMAND, 32'h0);
    ticks(3);
    k0 = n_rst;
    ticks(60);
    chk("restart stop", 32'(n_rst - k0), 32'h0);
    set_stall(1'b0);
    // Current mode: only the top five demand bits count
    wr(`BDM_OFS_CTRL, 32'h05);
    wr(`BDM_OFS_DEMAND, 32'h21f);
    ticks(30);
    chk("thr mid", current_threshold, 5'h10);
    wr(`BDM_OFS_DEMAND, 32'h01f);
    ticks(30);
    chk("thr low bits", current_threshold, 5'h00);
    // Speed mode: reference is demand times the step
    wr(`BDM_OFS_CTRL, 32'h09);
    wr(`BDM_OFS_DEMAND, 32'h3);
    for (int k = 0; k < 6; k++)
    begin
      wr(`BDM_OFS_CONFIG, 32'(k) << `BDM_CFG_RES_LO);
      rd(`BDM_OFS_SPEED);
      chk("speed ref", q[15:0], 16'h3 << k);
    end
    ticks(5);
    chk("coast below ramp", bridge_enable, 1'b0);
    wr(`BDM_OFS_CONFIG, 32'h0);
    k0 = n_st;
    wr(`BDM_OFS_DEMAND, 32'd800);
    wait_for(bridge_enable, 1'b1, "speed start");
    chk("limit speed", current_limit_active, 1'b1);
    wait_for(seq_synced, 1'b1, "speed sync");
    chk("start pulse", 32'(n_st - k0), 32'h1);
    d0 = peak_duty;
    ticks(100);
    chk("duty rises", 32'(peak_duty > d0), 32'h1);
    set_stall(1'b1);
    wait_for(sync_lost_flag, 1'b1, "speed loss");
    ticks(2);
    chk("speed off", bridge_enable, 1'b0);
    set_stall(1'b0);
    rd(`BDM_OFS_STATUS);
    ticks(20);
    chk("speed held", bridge_enable, 1'b0);
    wr(`BDM_OFS_CTRL, 32'h08);
    wr(`BDM_OFS_CTRL, 32'h09);
    wait_for(bridge_enable, 1'b1, "speed rerun");
    // Speed mode auto restart keeps the bridge running above ramp end
    wr(`BDM_OFS_CTRL, 32'h0b);
    wait_for(seq_synced, 1'b1, "speed resync");
    k0 = n_rst;
    set_stall(1'b1);
    ticks(80);
    chk("speed restarts", 32'(n_rst - k0 >= 2), 32'h1);
    chk("speed restart on", bridge_enable, 1'b1);
    set_stall(1'b0);
    wr(`BDM_OFS_CTRL, 32'h08);
    ticks(2);
    chk("run off", {bridge_enable, bridge_pwm}, 2'b00);
    print_verdict();
  end
endmodule
